// *** design/ovs_pkg.sv ***
// Shared constants and types of the overvoltage stage block.
package ovs_pkg;

	// Structure sizes.
	localparam int STAGES = 4;
	localparam int GROUPS = 8;
	localparam int OUTS = 3;
	localparam int MAG_W = 16;

	// Time base: one stamp count is one millisecond at the 8 ns clock.
	localparam int CLK_PERIOD_NS = 8;
	localparam int STAMP_RES_NS = 1000000;
	localparam int MS_CYCLES = STAMP_RES_NS / CLK_PERIOD_NS;

	// Measurement refresh and pre-fault averaging window.
	localparam int MEAS_BASE_MS = 5;
	localparam int AVG_WINDOW_MS = 20;
	localparam int AVG_SAMPLES = AVG_WINDOW_MS / MEAS_BASE_MS;

	// Release level in percent of the pick-up threshold.
	localparam logic [6:0] RELEASE_PCT = 7'h61;
	localparam logic [6:0] PCT_FULL = 7'h64;

	// Inverse-time accumulator scale against the delay setting.
	localparam int IDMT_SHIFT = 8;

	// Measured magnitude selection codes.
	localparam logic [1:0] MSEL_LL = 2'h0;
	localparam logic [1:0] MSEL_LN = 2'h1;
	localparam logic [1:0] MSEL_CH3 = 2'h2;
	localparam logic [1:0] MSEL_CH4 = 2'h3;

	// Voltage transformer connection codes.
	localparam logic [1:0] CONN_3LN_U4 = 2'h0;
	localparam logic [1:0] CONN_3LL_U4 = 2'h1;
	localparam logic [1:0] CONN_TWO_LINE_PLUS_AUX = 2'h2;

	// Logical node setting codes.
	localparam logic [2:0] LN_ON = 3'h1;
	localparam logic [2:0] LN_BLOCKED = 3'h2;
	localparam logic [2:0] LN_TEST = 3'h3;
	localparam logic [2:0] LN_TEST_BLOCKED = 3'h4;
	localparam logic [2:0] LN_OFF = 3'h5;

	// Status override codes.
	localparam logic [1:0] OVR_NORMAL = 2'h0;
	localparam logic [1:0] OVR_START = 2'h1;
	localparam logic [1:0] OVR_TRIP = 2'h2;
	localparam logic [1:0] OVR_BLOCKED = 2'h3;

	// Delay characteristic codes.
	localparam logic [1:0] DLY_INSTANT = 2'h0;
	localparam logic [1:0] DLY_DT = 2'h1;
	localparam logic [1:0] DLY_IDMT = 2'h2;

	// Output positions within one stage.
	localparam int OUT_START = 0;
	localparam int OUT_TRIP = 1;
	localparam int OUT_BLOCKED = 2;

	// Configuration write kinds.
	localparam logic CFG_GROUP = 1'b0;
	localparam logic CFG_GENERAL = 1'b1;

	// Settings held per stage and per setting group.
	typedef struct packed {
		logic [15:0] thr;
		logic [15:0] delay;
		logic [1:0] opmode;
		logic [1:0] dmode;
	} grp_t;

	// Static settings held per stage.
	typedef struct packed {
		logic [1:0] msel;
		logic [2:0] ln;
		logic [1:0] ovr;
	} gen_t;

	// Reset values.
	localparam grp_t GRP_RESET = '{16'hffff, 16'h0000, 2'h0, DLY_INSTANT};
	localparam gen_t GEN_RESET = '{MSEL_LL, LN_ON, OVR_NORMAL};

endpackage

// *** design/stage_if.sv ***
// Interface between the stage bank and one overvoltage stage core.
`timescale 1ns/1ps
`default_nettype none
interface stage_if;
	logic [1:0] n;                 // Number of supervised channels.
	logic [2:0][15:0] mag;         // Selected magnitudes.
	ovs_pkg::grp_t set;            // Active group settings.
	logic [2:0] ln;                // Effective logical node setting.
	logic block;                   // Blocking input.
	logic meas_tick;               // Measurement update strobe.
	logic ms_tick;                 // Millisecond strobe.
	logic start;                   // Stage start.
	logic trip;                    // Stage trip.
	logic blocked;                 // Stage blocked.
	logic [15:0] pf;               // Pre-fault average.

	// The core consumes measurements and settings.
	modport stage(input n, mag, set, ln, block, meas_tick, ms_tick,
		output start, trip, blocked, pf);
	// The bank supplies them and collects results.
	modport bank(output n, mag, set, ln, block, meas_tick, ms_tick,
		input start, trip, blocked, pf);
endinterface
`default_nettype wire

// *** design/ms_timebase.sv ***
// Millisecond strobe and time stamp counter.
`timescale 1ns/1ps
`default_nettype none
module ms_timebase #(
	parameter int MS_CYCLES = ovs_pkg::MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	output logic ms_tick,
	output logic [31:0] stamp
);
	typedef struct packed {
		logic [31:0] div;
		logic tick;
		logic [31:0] stamp;
	} tb_st_t;

	tb_st_t q, d;

	// Count clock cycles and step the stamp once per millisecond.
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.div >= 32'(MS_CYCLES - 1)) begin
			d.div = 32'h0000_0000;
			d.tick = 1'b1;
			d.stamp = q.stamp + 32'h0000_0001;
		end else begin
			d.div = q.div + 32'h0000_0001;
		end
	end

	// State register.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign ms_tick = q.tick;
	assign stamp = q.stamp;

	chk_stamp_step: assert property (@(posedge ref_clk) disable iff (rst)
		q.tick |-> q.stamp == $past(q.stamp) + 32'h1)
		else $error("stamp did not advance with the millisecond strobe");
endmodule
`default_nettype wire

// *** design/stage_core.sv ***
// Pick-up, blocking, delay and pre-fault logic of one stage.
`timescale 1ns/1ps
`default_nettype none
module stage_core (
	input wire logic ref_clk,
	input wire logic rst,
	stage_if.stage sif
);
	typedef struct packed {
		logic picked;
		logic start;
		logic trip;
		logic blocked;
		logic [31:0] tmr;
		logic [ovs_pkg::AVG_SAMPLES-1:0][15:0] hist;
		logic [15:0] pf;
	} core_st_t;

	core_st_t q, d;
	logic [15:0] rel;     // Release level.
	logic [15:0] maxm;    // Largest supervised magnitude.
	logic [1:0] cnt;      // Channels above their level.
	logic [1:0] need;     // Channels needed for pick-up.
	logic pick;           // Pick-up condition.
	logic inhibit;        // Logical node holds start and trip off.

	// Mean of the history samples.
	function automatic logic [15:0] avg(
		input logic [ovs_pkg::AVG_SAMPLES-1:0][15:0] h);
		logic [31:0] s;
		s = 32'h0;
		for (int i = 0; i < ovs_pkg::AVG_SAMPLES; i++) begin
			s = s + 32'(h[i]);
		end
		return 16'(s / 32'(ovs_pkg::AVG_SAMPLES));
	endfunction

	// Evaluate the stage and advance the delay timer.
	always_comb begin
		d = q;
		rel = 16'((32'(sif.set.thr) * 32'(ovs_pkg::RELEASE_PCT)) /
			32'(ovs_pkg::PCT_FULL));
		cnt = 2'h0;
		maxm = 16'h0;
		for (int i = 0; i < 3; i++) begin
			if (2'(i) < sif.n) begin
				// Held pick-up stays while at or above the release level.
				if (q.picked ? sif.mag[i] >= rel : sif.mag[i] > sif.set.thr) begin
					cnt = cnt + 2'h1;
				end
				if (sif.mag[i] > maxm) begin
					maxm = sif.mag[i];
				end
			end
		end
		// Single channel selections need one voltage only.
		if (sif.n == 2'h1) begin
			need = 2'h1;
		end else if (sif.set.opmode >= 2'h2) begin
			need = 2'h3;
		end else begin
			need = sif.set.opmode + 2'h1;
		end
		pick = (sif.n != 2'h0) && (cnt >= need);
		inhibit = (sif.ln == ovs_pkg::LN_BLOCKED) ||
			(sif.ln == ovs_pkg::LN_OFF);
		if (sif.meas_tick) begin
			// Shift the newest sample into the averaging window.
			d.hist = {q.hist[ovs_pkg::AVG_SAMPLES-2:0], maxm};
			if (!pick) begin
				// Release clears pick-up, start, trip, blocked and the timer; the pre-fault value holds.
				d.picked = 1'b0;
				d.start = 1'b0;
				d.trip = 1'b0;
				d.blocked = 1'b0;
				d.tmr = 32'h0;
			end else if (!q.picked) begin
				// New pick-up: the block check decides the path.
				d.picked = 1'b1;
				d.tmr = 32'h0;
				if (sif.block) begin
					d.blocked = 1'b1;
				end else begin
					d.start = 1'b1;
					d.trip = sif.set.dmode == ovs_pkg::DLY_INSTANT;
				end
			end else if (q.start && sif.block) begin
				// A late block resets the started stage.
				d.start = 1'b0;
				d.trip = 1'b0;
				d.blocked = 1'b1;
				d.tmr = 32'h0;
			end else if (q.start && sif.set.dmode == ovs_pkg::DLY_INSTANT) begin
				d.trip = 1'b1;
			end
		end
		// Delay timing runs on the millisecond strobe.
		if (sif.ms_tick && d.start && !d.trip) begin
			if (sif.set.dmode == ovs_pkg::DLY_DT) begin
				d.tmr = d.tmr + 32'h1;
				d.trip = d.tmr >= 32'(sif.set.delay);
			end else if (sif.set.dmode == ovs_pkg::DLY_IDMT) begin
				// Excess voltage accumulates, so higher faults trip sooner.
				if (maxm > sif.set.thr) begin
					d.tmr = d.tmr + 32'(maxm - sif.set.thr);
				end
				d.trip = d.tmr >= (32'(sif.set.delay) << ovs_pkg::IDMT_SHIFT);
			end
		end
		if (inhibit) begin
			d.start = 1'b0;
			d.trip = 1'b0;
			d.picked = 1'b0;
			d.tmr = 32'h0;
		end
		// Latch the pre-fault average on a start or trip edge.
		if ((d.start && !q.start) || (d.trip && !q.trip)) begin
			d.pf = avg(d.hist);
		end
	end

	// State register.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sif.start = q.start;
	assign sif.trip = q.trip;
	assign sif.blocked = q.blocked;
	assign sif.pf = q.pf;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	chk_ln_hold: assert property (inhibit |=> !q.start && !q.trip)
		else $error("start or trip active under blocked or off mode");
	chk_block_excl: assert property (!(q.start && q.blocked))
		else $error("blocked and start active together");
	chk_instant_trip: assert property (
		q.start && !$past(q.start) &&
		$past(sif.set.dmode) == ovs_pkg::DLY_INSTANT |-> q.trip)
		else $error("instant mode start without trip");
	chk_eval_tick: assert property (
		$rose(q.picked) |-> $past(sif.meas_tick))
		else $error("pick-up outside a measurement update");
endmodule
`default_nettype wire

// *** design/ovs_bank.sv ***
// Four overvoltage stages with settings, events and counters.
// Functional notes
// - Four independent stages with own settings.
// - Supervise line-to-line or line-to-neutral voltages.
// - Eight setting groups, one common selector.
// - Settings, block and group apply while running.
// - Instant, definite-time or inverse-time delay.
// - ON and OFF events per output change.
// - Instant start and trip share one stamp.
// - Event stamps count whole milliseconds.
// - Resettable start, trip, blocked event counters.
// - Eight RMS inputs refreshed every 5 ms.
// - Pre-fault value averages last 20 ms.
// - Selector codes line, earth, third, fourth.
// - Third channel only with two-line-plus-aux wiring.
// - No earth voltages without neutral channels.
// - General settings independent of setting groups.
// - Logical node codes one to five, gated.
// - Override forces outputs only when forcing enabled.
// - Pick-up over threshold, release below 97 percent.
// - Block at pick-up gives blocked, not start.
`timescale 1ns/1ps
`default_nettype none
module ovs_bank #(
	parameter int MS_CYCLES = ovs_pkg::MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0][15:0] mag_ll,
	input wire logic [2:0][15:0] mag_ln,
	input wire logic [15:0] mag_ch3,
	input wire logic [15:0] mag_ch4,
	input wire logic meas_valid,
	input wire logic [1:0] conn_mode,
	input wire logic [3:0] block_in,
	input wire logic [2:0] group_sel,
	input wire logic allow_ln_setting,
	input wire logic stage_forcing_en,
	input wire logic cfg_we,
	input wire logic cfg_kind,
	input wire logic [1:0] cfg_stage,
	input wire logic [2:0] cfg_group,
	input wire logic [35:0] cfg_data,
	input wire logic [3:0] cnt_clr,
	output logic [3:0] start_o,
	output logic [3:0] trip_o,
	output logic [3:0] blocked_o,
	output logic [11:0] ev_on,
	output logic [11:0] ev_off,
	output logic [31:0] ev_stamp,
	output logic [11:0][15:0] ev_count,
	output logic [3:0][15:0] prefault
);
	////////////////////////////////////////////////////////////////////////
	// Types and state.

	// Channels chosen for supervision.
	typedef struct packed {
		logic [1:0] n;
		logic [2:0][15:0] m;
	} sel_t;

	// Whole state of the bank.
	typedef struct packed {
		ovs_pkg::grp_t [3:0][7:0] grp;
		ovs_pkg::gen_t [3:0] gen;
		logic [11:0] out;
		logic [11:0] on;
		logic [11:0] off;
		logic [31:0] stamp;
		logic [11:0][15:0] cnt;
		logic [3:0][15:0] pf;
	} bank_st_t;

	bank_st_t q, d;
	logic ms_tick;                 // Millisecond strobe.
	logic [31:0] tb_stamp;         // Running millisecond stamp.
	logic [3:0][2:0] st_out;       // Core outputs blocked, trip, start.
	logic [3:0][15:0] st_pf;       // Core pre-fault values.
	logic [11:0] nxt;              // Next output vector.
	ovs_pkg::gen_t wgen;           // General word being written.

	////////////////////////////////////////////////////////////////////////
	// Functions.

	// Pick the supervised channels for a selection code.
	function automatic sel_t sel_mags(input logic [1:0] msel,
		input logic [1:0] conn, input logic [2:0][15:0] ll,
		input logic [2:0][15:0] ln, input logic [15:0] c3,
		input logic [15:0] c4);
		sel_t r;
		r.n = 2'h0;
		r.m = '0;
		if (msel == ovs_pkg::MSEL_LL) begin
			r.n = 2'h3;
			r.m = ll;
		end else if (msel == ovs_pkg::MSEL_LN) begin
			// Earth voltages exist only with neutral wiring.
			if (conn == ovs_pkg::CONN_3LN_U4) begin
				r.n = 2'h3;
				r.m = ln;
			end
		end else if (msel == ovs_pkg::MSEL_CH3) begin
			if (conn == ovs_pkg::CONN_TWO_LINE_PLUS_AUX) begin
				r.n = 2'h1;
				r.m[0] = c3;
			end
		end else begin
			r.n = 2'h1;
			r.m[0] = c4;
		end
		return r;
	endfunction

	// Flat output index of a stage output.
	function automatic int oidx(input int s, input int k);
		return s * ovs_pkg::OUTS + k;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Time base and stage cores.

	// Millisecond stamp shared by all stages.
	ms_timebase #(.MS_CYCLES(MS_CYCLES)) u_tb (
		.ref_clk(ref_clk),
		.rst(rst),
		.ms_tick(ms_tick),
		.stamp(tb_stamp)
	);

	// One core per stage, each with its own settings and outputs.
	for (genvar s = 0; s < ovs_pkg::STAGES; s++) begin : g_stage
		stage_if sif();
		sel_t sel;
		// Selection comes from the static settings only.
		assign sel = sel_mags(q.gen[s].msel, conn_mode, mag_ll, mag_ln,
			mag_ch3, mag_ch4);
		assign sif.n = sel.n;
		assign sif.mag = sel.m;
		// The common selector picks the active group on the fly.
		assign sif.set = q.grp[s][group_sel];
		assign sif.ln = allow_ln_setting ? q.gen[s].ln : ovs_pkg::LN_ON;
		assign sif.block = block_in[s];
		assign sif.meas_tick = meas_valid;
		assign sif.ms_tick = ms_tick;
		assign st_out[s] = {sif.blocked, sif.trip, sif.start};
		assign st_pf[s] = sif.pf;
		stage_core u_core (
			.ref_clk(ref_clk),
			.rst(rst),
			.sif(sif)
		);
	end

	assign wgen = ovs_pkg::gen_t'(cfg_data[6:0]);

	////////////////////////////////////////////////////////////////////////
	// Settings, outputs, events and counters.

	// Next state of the whole bank.
	always_comb begin
		d = q;
		nxt = '0;
		if (cfg_we && cfg_kind == ovs_pkg::CFG_GROUP) begin
			// Group settings go to the addressed group only.
			d.grp[cfg_stage][cfg_group] = ovs_pkg::grp_t'(cfg_data);
		end else if (cfg_we) begin
			// Static settings are not part of any group.
			if (wgen.msel != ovs_pkg::MSEL_LN ||
				conn_mode == ovs_pkg::CONN_3LN_U4) begin
				d.gen[cfg_stage].msel = wgen.msel;
			end
			if (allow_ln_setting && wgen.ln >= ovs_pkg::LN_ON &&
				wgen.ln <= ovs_pkg::LN_OFF) begin
				d.gen[cfg_stage].ln = wgen.ln;
			end
			d.gen[cfg_stage].ovr = wgen.ovr;
		end
		for (int s = 0; s < ovs_pkg::STAGES; s++) begin
			nxt[oidx(s, 0) +: 3] = st_out[s];
			// Forcing replaces the stage result while enabled.
			if (stage_forcing_en && q.gen[s].ovr != ovs_pkg::OVR_NORMAL) begin
				nxt[oidx(s, 0) +: 3] = 3'h0;
				if (q.gen[s].ovr == ovs_pkg::OVR_START) begin
					nxt[oidx(s, ovs_pkg::OUT_START)] = 1'b1;
				end else if (q.gen[s].ovr == ovs_pkg::OVR_TRIP) begin
					nxt[oidx(s, ovs_pkg::OUT_TRIP)] = 1'b1;
				end else begin
					nxt[oidx(s, ovs_pkg::OUT_BLOCKED)] = 1'b1;
				end
			end
		end
		d.out = nxt;
		d.on = nxt & ~q.out;
		d.off = ~nxt & q.out;
		if (|(d.on | d.off)) begin
			d.stamp = tb_stamp;
		end
		// A count in the clearing cycle survives the clear.
		for (int j = 0; j < 12; j++) begin
			if (d.on[j]) begin
				d.cnt[j] = (cnt_clr[j / 3] ? 16'h0 : q.cnt[j]) + 16'h1;
			end else if (cnt_clr[j / 3]) begin
				d.cnt[j] = 16'h0;
			end
		end
		d.pf = st_pf;
	end

	// State register with reset values.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q <= '0;
			for (int s = 0; s < ovs_pkg::STAGES; s++) begin
				q.gen[s] <= ovs_pkg::GEN_RESET;
				for (int g = 0; g < ovs_pkg::GROUPS; g++) begin
					q.grp[s][g] <= ovs_pkg::GRP_RESET;
				end
			end
		end else begin
			q <= d;
		end
	end

	// Output mapping straight from the state register.
	for (genvar s = 0; s < ovs_pkg::STAGES; s++) begin : g_out
		assign start_o[s] = q.out[s * 3 + ovs_pkg::OUT_START];
		assign trip_o[s] = q.out[s * 3 + ovs_pkg::OUT_TRIP];
		assign blocked_o[s] = q.out[s * 3 + ovs_pkg::OUT_BLOCKED];
	end
	assign ev_on = q.on;
	assign ev_off = q.off;
	assign ev_stamp = q.stamp;
	assign ev_count = q.cnt;
	assign prefault = q.pf;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	chk_on_events: assert property (
		ev_on == (q.out & ~$past(q.out)))
		else $error("ON event does not match an output rise");
	chk_off_events: assert property (
		ev_off == (~q.out & $past(q.out)))
		else $error("OFF event does not match an output fall");
	chk_event_stamp: assert property (
		|(ev_on | ev_off) |-> ev_stamp == $past(tb_stamp))
		else $error("event stamp differs from the time base");
	chk_count_step: assert property (
		ev_on[0] && !$past(cnt_clr[0]) |->
		ev_count[0] == $past(ev_count[0]) + 16'h1)
		else $error("start counter did not step on its event");
	chk_count_clear: assert property (
		$past(cnt_clr[0]) && !ev_on[0] |-> ev_count[0] == 16'h0)
		else $error("counter clear was not applied");
	chk_force_trip: assert property (
		stage_forcing_en && q.gen[0].ovr == ovs_pkg::OVR_TRIP |=>
		trip_o[0] && !start_o[0] && !blocked_o[0])
		else $error("forced trip not shown on the outputs");
	chk_earth_reject: assert property (
		cfg_we && cfg_kind == ovs_pkg::CFG_GENERAL &&
		conn_mode != ovs_pkg::CONN_3LN_U4 && cfg_stage == 2'h0 |=>
		q.gen[0].msel != ovs_pkg::MSEL_LN || $past(q.gen[0].msel) ==
		ovs_pkg::MSEL_LN)
		else $error("earth selection accepted without neutral wiring");

	cov_start: cover property ($rose(start_o[0]));
	cov_trip: cover property ($rose(trip_o[0]));
	cov_blocked: cover property ($rose(blocked_o[0]));
	cov_clear: cover property (cnt_clr[0] && ev_on[0]);
endmodule
`default_nettype wire

// *** verif/meas_src.sv ***
// Measurement front end model that announces a new magnitude set every period.
`timescale 1ns/1ps
`default_nettype none
module meas_src #(
	parameter int PERIOD = 50
) (
	input wire logic ref_clk,
	input wire logic rst,
	output logic meas_valid
);
	int cnt; // Cycles since the last measurement set.

	// One-cycle strobe every measurement period, launched off the falling edge.
	always @(negedge ref_clk) begin
		if (rst) begin
			cnt <= 0;
			meas_valid <= 1'b0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			meas_valid <= (cnt == PERIOD - 1);
		end
	end
endmodule
`default_nettype wire

// *** verif/ovs_bank_tb.sv ***
// Self-checking testbench of the overvoltage stage bank.
`timescale 1ns/1ps
`default_nettype none
module ovs_bank_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0][15:0] mag_ll = '0;
	logic [2:0][15:0] mag_ln = '0;
	logic [15:0] mag_ch3 = 16'h0000;
	logic [15:0] mag_ch4 = 16'h0000;
	logic meas_valid;
	logic [1:0] conn_mode = 2'h0;
	logic [3:0] block_in = 4'h0;
	logic [2:0] group_sel = 3'h0;
	logic allow_ln_setting = 1'b0;
	logic stage_forcing_en = 1'b0;
	logic cfg_we = 1'b0;
	logic cfg_kind = 1'b0;
	logic [1:0] cfg_stage = 2'h0;
	logic [2:0] cfg_group = 3'h0;
	logic [35:0] cfg_data = '0;
	logic [3:0] cnt_clr = 4'h0;
	logic [3:0] start_o, trip_o, blocked_o;
	logic [11:0] ev_on, ev_off;
	logic [31:0] ev_stamp;
	logic [11:0][15:0] ev_count;
	logic [3:0][15:0] prefault;
	int n_fail = 0; // Mismatches seen.
	int tests_run = 0; // Comparisons made.
	int n_both = 0; // Cycles with start and trip ON events of stage 0 together.
	int n_off0 = 0; // Start OFF events of stage 0.
	localparam int TB_MS = 10; // Clock cycles per millisecond in simulation.
	int n_edge = 0; // Clock edges since reset was released.
	logic [15:0] stamp_exp = 16'h0000; // Stamp the bench expects.
	logic [15:0] stamp_seen = 16'hffff; // Stamp of the last joint event.

	// The clock toggles every half period of 8 ns.
	always #4 ref_clk = ~ref_clk;

	ovs_bank #(.MS_CYCLES(TB_MS)) ovs_bank_i (.ref_clk(ref_clk), .rst(rst),
		.mag_ll(mag_ll), .mag_ln(mag_ln), .mag_ch3(mag_ch3),
		.mag_ch4(mag_ch4), .meas_valid(meas_valid), .conn_mode(conn_mode),
		.block_in(block_in), .group_sel(group_sel),
		.allow_ln_setting(allow_ln_setting),
		.stage_forcing_en(stage_forcing_en), .cfg_we(cfg_we),
		.cfg_kind(cfg_kind), .cfg_stage(cfg_stage), .cfg_group(cfg_group),
		.cfg_data(cfg_data), .cnt_clr(cnt_clr), .start_o(start_o),
		.trip_o(trip_o), .blocked_o(blocked_o), .ev_on(ev_on),
		.ev_off(ev_off), .ev_stamp(ev_stamp), .ev_count(ev_count),
		.prefault(prefault));

	meas_src #(.PERIOD(50)) meas_src_i (.ref_clk(ref_clk), .rst(rst),
		.meas_valid(meas_valid));

	// Event pulses last one cycle; they are counted mid-cycle, when settled.
	always @(negedge ref_clk) begin
		if (ev_on[0] === 1'b1 && ev_on[1] === 1'b1) begin
			n_both <= n_both + 1;
			stamp_exp <= 16'((n_edge - 1) / TB_MS);
			stamp_seen <= ev_stamp[15:0];
		end
		if (ev_off[0] === 1'b1) begin
			n_off0 <= n_off0 + 1;
		end
	end

	// The bench keeps its own millisecond count from the edges since reset.
	always @(posedge ref_clk) begin
		if (rst === 1'b0) begin
			n_edge <= n_edge + 1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared tasks.

	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Compares one observed value with its expectation.
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Writes one configuration word with a one-cycle strobe.
	task automatic cfg(input logic kind, input logic [1:0] stg,
		input logic [2:0] grp, input logic [35:0] data);
		cfg_we = 1'b1;
		cfg_kind = kind;
		cfg_stage = stg;
		cfg_group = grp;
		cfg_data = data;
		@(negedge ref_clk);
		cfg_we = 1'b0;
	endtask

	// Writes the threshold of one group as an instant single-channel stage.
	task automatic set_thr(input logic [1:0] stg, input logic [2:0] grp,
		input logic [15:0] thr);
		cfg(ovs_pkg::CFG_GROUP, stg, grp,
			{thr, 16'h0000, 2'h0, ovs_pkg::DLY_INSTANT});
	endtask

	// Writes the static settings of one stage.
	task automatic set_gen(input logic [1:0] stg, input logic [1:0] msel,
		input logic [2:0] ln, input logic [1:0] ovr);
		cfg(ovs_pkg::CFG_GENERAL, stg, 3'h0, {29'h0, msel, ln, ovr});
	endtask

	// Waits for the next measurement set and lets the results settle.
	task automatic settle();
		int i;
		// Only a strobe taken after the new inputs were applied counts.
		for (i = 0; i < 200; i++) begin
			@(posedge ref_clk);
			if (meas_valid === 1'b1) begin
				break;
			end
		end
		if (meas_valid !== 1'b1) begin
			n_fail++;
			$display("[ERR] meas_valid expected 1 seen %b", meas_valid);
			end_of_test();
		end
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios.

	// Instant pick-up, hysteresis, events and counter clear on stage 0.
	task automatic t_instant();
		int b0;
		int f0;
		b0 = n_both;
		f0 = n_off0;
		set_thr(2'h0, 3'h0, 16'h0064);
		mag_ll[0] = 16'h00c8;
		settle();
		chk("start0", 16'h0001, {15'h0000, start_o[0]});
		chk("trip0", 16'h0001, {15'h0000, trip_o[0]});
		chk("both_on", 16'h0001, 16'(n_both - b0));
		chk("count0", 16'h0001, ev_count[0]);
		chk("stamp0", stamp_exp, stamp_seen);
		chk("pf0", 16'h0032, prefault[0]);
		settle();
		chk("count0_again", 16'h0001, ev_count[0]);
		mag_ll[0] = 16'h0062;
		settle();
		chk("start0_held", 16'h0001, {15'h0000, start_o[0]});
		mag_ll[0] = 16'h0060;
		settle();
		chk("start0_rel", 16'h0000, {15'h0000, start_o[0]});
		chk("off0", 16'h0001, 16'(n_off0 - f0));
		cnt_clr = 4'h1;
		@(negedge ref_clk);
		cnt_clr = 4'h0;
		@(negedge ref_clk);
		chk("count0_clr", 16'h0000, ev_count[0]);
		$display("t_instant done");
	endtask

	// Blocking at pick-up on stage 1 gives blocked instead of start.
	task automatic t_block();
		block_in = 4'h2;
		set_thr(2'h1, 3'h0, 16'h0064);
		mag_ll[0] = 16'h00c8;
		settle();
		chk("blocked1", 16'h0001, {15'h0000, blocked_o[1]});
		chk("start1", 16'h0000, {15'h0000, start_o[1]});
		chk("start0_free", 16'h0001, {15'h0000, start_o[0]});
		chk("count_blk1", 16'h0001, ev_count[5]);
		mag_ll[0] = 16'h0000;
		block_in = 4'h0;
		settle();
		$display("t_block done");
	endtask

	// The common group selector switches stage 2 while running.
	task automatic t_group();
		set_thr(2'h2, 3'h3, 16'h0064);
		mag_ll[0] = 16'h00c8;
		settle();
		chk("start2_g0", 16'h0000, {15'h0000, start_o[2]});
		group_sel = 3'h3;
		settle();
		chk("start2_g3", 16'h0001, {15'h0000, start_o[2]});
		group_sel = 3'h0;
		mag_ll[0] = 16'h0000;
		settle();
		$display("t_group done");
	endtask

	// Two-voltage definite-time stage 2 and inverse-time stage 1.
	task automatic t_delay();
		cfg(ovs_pkg::CFG_GROUP, 2'h2, 3'h0, {16'h0064, 16'h0003, 2'h1,
			ovs_pkg::DLY_DT});
		@(negedge ref_clk);
		cfg(ovs_pkg::CFG_GROUP, 2'h1, 3'h0, {16'h0064, 16'h0001, 2'h0,
			ovs_pkg::DLY_IDMT});
		mag_ll[0] = 16'h00c8;
		settle();
		chk("start2_one", 16'h0000, {15'h0000, start_o[2]});
		chk("trip1_wait", 16'h0000, {15'h0000, trip_o[1]});
		mag_ll[1] = 16'h00c8;
		settle();
		chk("trip1_idmt", 16'h0001, {15'h0000, trip_o[1]});
		chk("start2_two", 16'h0001, {15'h0000, start_o[2]});
		chk("trip2_wait", 16'h0000, {15'h0000, trip_o[2]});
		repeat (40) @(negedge ref_clk);
		chk("trip2_dt", 16'h0001, {15'h0000, trip_o[2]});
		mag_ll = '0;
		settle();
		$display("t_delay done");
	endtask

	// Logical node setting Off holds stage 0 quiet; writes need permission.
	task automatic t_lnode();
		allow_ln_setting = 1'b1;
		set_gen(2'h0, ovs_pkg::MSEL_LL, ovs_pkg::LN_OFF, ovs_pkg::OVR_NORMAL);
		mag_ll[0] = 16'h00c8;
		settle();
		chk("start0_off", 16'h0000, {15'h0000, start_o[0]});
		allow_ln_setting = 1'b0;
		set_gen(2'h0, ovs_pkg::MSEL_LL, ovs_pkg::LN_ON, ovs_pkg::OVR_NORMAL);
		allow_ln_setting = 1'b1;
		settle();
		chk("start0_deny", 16'h0000, {15'h0000, start_o[0]});
		set_gen(2'h0, ovs_pkg::MSEL_LL, ovs_pkg::LN_ON, ovs_pkg::OVR_NORMAL);
		settle();
		chk("start0_on", 16'h0001, {15'h0000, start_o[0]});
		mag_ll[0] = 16'h0000;
		$display("t_lnode done");
	endtask

	// Magnitude selector codes against the wiring on stage 0.
	task automatic t_select();
		set_gen(2'h0, ovs_pkg::MSEL_LN, ovs_pkg::LN_ON, ovs_pkg::OVR_NORMAL);
		mag_ln[0] = 16'h00c8;
		settle();
		chk("sel_ln", 16'h0001, {15'h0000, start_o[0]});
		conn_mode = ovs_pkg::CONN_3LL_U4;
		settle();
		chk("sel_ln_3ll", 16'h0000, {15'h0000, start_o[0]});
		mag_ln[0] = 16'h0000;
		conn_mode = ovs_pkg::CONN_TWO_LINE_PLUS_AUX;
		set_gen(2'h0, ovs_pkg::MSEL_CH3, ovs_pkg::LN_ON, ovs_pkg::OVR_NORMAL);
		mag_ch3 = 16'h00c8;
		settle();
		chk("sel_ch3", 16'h0001, {15'h0000, start_o[0]});
		set_gen(2'h0, ovs_pkg::MSEL_LN, ovs_pkg::LN_ON, ovs_pkg::OVR_NORMAL);
		settle();
		chk("sel_ln_refused", 16'h0001, {15'h0000, start_o[0]});
		conn_mode = ovs_pkg::CONN_3LN_U4;
		settle();
		chk("sel_ch3_3ln", 16'h0000, {15'h0000, start_o[0]});
		mag_ch3 = 16'h0000;
		set_gen(2'h0, ovs_pkg::MSEL_CH4, ovs_pkg::LN_ON, ovs_pkg::OVR_NORMAL);
		mag_ch4 = 16'h00c8;
		settle();
		chk("sel_ch4", 16'h0001, {15'h0000, start_o[0]});
		mag_ch4 = 16'h0000;
		settle();
		$display("t_select done");
	endtask

	// Every override code on stage 3, then the global enable gates it.
	task automatic t_force();
		int k;
		logic [2:0] want;
		stage_forcing_en = 1'b1;
		for (k = 0; k < 4; k++) begin
			set_gen(2'h3, ovs_pkg::MSEL_LL, ovs_pkg::LN_ON, 2'(k));
			repeat (3) @(negedge ref_clk);
			want = (k == 0) ? 3'h0 : 3'(1 << (k - 1));
			chk("force3", {13'h0000, want},
				{13'h0000, blocked_o[3], trip_o[3], start_o[3]});
		end
		stage_forcing_en = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("force3_off", 16'h0000, {13'h0000, blocked_o[3], trip_o[3],
			start_o[3]});
		$display("t_force done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.

	// Reset for three cycles, then run each scenario in turn.
	initial begin
		repeat (3) @(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		t_instant();
		t_block();
		t_group();
		t_delay();
		t_lnode();
		t_select();
		t_force();
		end_of_test();
	end
endmodule
`default_nettype wire
